// File: iprc_regs.svh
// register indices, bit positions, reset values and bus codes of the request/priority block
// assumes a 32-bit AXI4-Lite slave; byte address of a register is four times its index
`ifndef IPRC_REGS_SVH
`define IPRC_REGS_SVH

// register indices (byte address = index * 4)
`define IPRC_IDX_REQ0 12'hfc0
`define IPRC_IDX_ENH0 12'hfc1
`define IPRC_IDX_ENL0 12'hfc2
`define IPRC_IDX_REQ1 12'hfc3
`define IPRC_IDX_ENH1 12'hfc4
`define IPRC_IDX_ENL1 12'hfc5
`define IPRC_IDX_CTRL 12'hfc6
`define IPRC_IDX_EVST 12'hfc7
`define IPRC_IDX_EVMASK 12'hfc8
`define IPRC_IDX_VEC 12'hfc9

// first group bit positions
`define IPRC_BIT_TIMER2 7
`define IPRC_BIT_TIMER1 6
`define IPRC_BIT_TIMER0 5
`define IPRC_BIT_SERIAL0_RX 4
`define IPRC_BIT_SERIAL0_TX 3
`define IPRC_BIT_TWOWIRE 2
`define IPRC_BIT_SYNC_SERIAL 1
`define IPRC_BIT_CONVERTER 0

// control and event bits
`define IPRC_BIT_GLOBAL_EN 0
`define IPRC_BIT_EV_GROUP0 0
`define IPRC_BIT_EV_GROUP1 1

// reset values
`define IPRC_RST_BYTE 8'h00
`define IPRC_RST_EV 2'h0

// bus responses
`define IPRC_RESP_OKAY 2'h0
`define IPRC_RESP_SLVERR 2'h2

`endif

// File: iprc_pkg.sv
// types shared by the request/priority block
// assumes nothing beyond a SystemVerilog compiler
package iprc_pkg;

  // write channel sequencing
  typedef enum logic [1:0] {
    IPRC_WS_IDLE = 2'b01,
    IPRC_WS_RESP = 2'b10
  } iprc_wstate_t;

  // read channel sequencing
  typedef enum logic [1:0] {
    IPRC_RS_IDLE = 2'b01,
    IPRC_RS_DATA = 2'b10
  } iprc_rstate_t;

  // priority of one source: 0 disabled, 1..3 rising priority
  typedef logic [1:0] iprc_level_t;

endpackage

// File: iprc_ctrl.sv
// interrupt request capture, priority enable and vector selection behind an AXI4-Lite slave
// assumes all request inputs are one-cycle or level sets from logic on aclk (no sync needed)
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "iprc_regs.svh"

module iprc_ctrl
  import iprc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer2_request,
  input wire logic timer1_request,
  input wire logic timer0_request,
  input wire logic serial0_rx_request,
  input wire logic serial0_tx_request,
  input wire logic twowire_request,
  input wire logic sync_serial_request,
  input wire logic converter_request,
  input wire logic port_pin7_request,
  input wire logic port_pin6_request,
  input wire logic port_pin5_request,
  input wire logic port_pin4_request,
  input wire logic port_pin3_request,
  input wire logic port_pin2_request,
  input wire logic port_pin1_request,
  input wire logic port_pin0_request,
  output logic core_irq_valid,
  output logic [3:0] core_irq_vector,
  output iprc_level_t core_irq_level,
  output logic irq
);

  // register file
  logic [7:0] request_group0;
  logic [7:0] enable_high_group0;
  logic [7:0] enable_low_group0;
  logic [7:0] request_group1_pins;
  logic [7:0] enable_high_group1;
  logic [7:0] enable_low_group1;
  logic global_enable;
  logic [1:0] event_status;
  logic [1:0] event_mask;

  // bus state
  iprc_wstate_t wstate;
  iprc_rstate_t rstate;
  logic aw_got;
  logic w_got;
  logic [15:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic [11:0] wr_idx;
  logic wr_hit;
  logic wr_lane0;
  logic [11:0] rd_idx;
  logic rd_hit;
  logic [7:0] rd_byte;

  // hardware request sets, watchdog deliberately not among them
  logic [7:0] hw_set0;
  logic [7:0] hw_set1;
  logic [15:0] pending;
  logic [15:0] enh_all;
  logic [15:0] enl_all;
  iprc_level_t src_level [16];
  iprc_level_t best_level;
  logic [3:0] best_vector;

  // first group packing in documented bit order
  always_comb begin
    hw_set0 = 8'h00;
    hw_set0[`IPRC_BIT_TIMER2] = timer2_request;
    hw_set0[`IPRC_BIT_TIMER1] = timer1_request;
    hw_set0[`IPRC_BIT_TIMER0] = timer0_request;
    hw_set0[`IPRC_BIT_SERIAL0_RX] = serial0_rx_request;
    hw_set0[`IPRC_BIT_SERIAL0_TX] = serial0_tx_request;
    hw_set0[`IPRC_BIT_TWOWIRE] = twowire_request;
    hw_set0[`IPRC_BIT_SYNC_SERIAL] = sync_serial_request;
    hw_set0[`IPRC_BIT_CONVERTER] = converter_request;
  end

  // pin n lands on bit n
  assign hw_set1 = {port_pin7_request, port_pin6_request, port_pin5_request,
                    port_pin4_request, port_pin3_request, port_pin2_request,
                    port_pin1_request, port_pin0_request};

  // write path: address and data may arrive in either order
  assign do_write = (wstate == IPRC_WS_IDLE) && aw_got && w_got;
  assign wr_idx = aw_addr_q[13:2];
  assign wr_lane0 = do_write && w_strb_q[0];

  always_comb begin
    wr_hit = 1'b0;
    if (aw_addr_q[15:14] == 2'h0) begin
      case (wr_idx)
        `IPRC_IDX_REQ0, `IPRC_IDX_ENH0, `IPRC_IDX_ENL0, `IPRC_IDX_REQ1,
        `IPRC_IDX_ENH1, `IPRC_IDX_ENL1, `IPRC_IDX_CTRL, `IPRC_IDX_EVST,
        `IPRC_IDX_EVMASK, `IPRC_IDX_VEC: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
      endcase
    end
  end

  // address channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      aw_addr_q <= 16'h0000;
      s_axi_awready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_got <= 1'b0;
      end
      // ready drops right after a take so a second address waits
      s_axi_awready <= (wstate == IPRC_WS_IDLE) && !aw_got && !do_write
                       && !(s_axi_awvalid && s_axi_awready);
    end
  end

  // data channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_got <= 1'b0;
      end
      s_axi_wready <= (wstate == IPRC_WS_IDLE) && !w_got && !do_write
                      && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // write response; unmapped addresses answer slverr and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate <= IPRC_WS_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IPRC_RESP_OKAY;
    end else begin
      case (wstate)
        IPRC_WS_IDLE: begin
          if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `IPRC_RESP_OKAY : `IPRC_RESP_SLVERR;
            wstate <= IPRC_WS_RESP;
          end
        end
        IPRC_WS_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wstate <= IPRC_WS_IDLE;
          end
        end
        default: begin
          s_axi_bvalid <= 1'b0;
          wstate <= IPRC_WS_IDLE;
        end
      endcase
    end
  end

  // request registers: written value replaces, hardware sets are ored on top,
  // so a set arriving with a clearing write survives; recorded even when
  // interrupts are globally off so software can poll
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      request_group0 <= `IPRC_RST_BYTE;
      request_group1_pins <= `IPRC_RST_BYTE;
    end else begin
      if (wr_lane0 && wr_hit && wr_idx == `IPRC_IDX_REQ0) begin
        request_group0 <= w_data_q[7:0] | hw_set0;
      end else begin
        request_group0 <= request_group0 | hw_set0;
      end
      if (wr_lane0 && wr_hit && wr_idx == `IPRC_IDX_REQ1) begin
        request_group1_pins <= w_data_q[7:0] | hw_set1;
      end else begin
        request_group1_pins <= request_group1_pins | hw_set1;
      end
    end
  end

  // enable pairs and global enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_high_group0 <= `IPRC_RST_BYTE;
      enable_low_group0 <= `IPRC_RST_BYTE;
      enable_high_group1 <= `IPRC_RST_BYTE;
      enable_low_group1 <= `IPRC_RST_BYTE;
      global_enable <= 1'b0;
    end else if (wr_lane0 && wr_hit) begin
      case (wr_idx)
        `IPRC_IDX_ENH0: enable_high_group0 <= w_data_q[7:0];
        `IPRC_IDX_ENL0: enable_low_group0 <= w_data_q[7:0];
        `IPRC_IDX_ENH1: enable_high_group1 <= w_data_q[7:0];
        `IPRC_IDX_ENL1: enable_low_group1 <= w_data_q[7:0];
        `IPRC_IDX_CTRL: global_enable <= w_data_q[`IPRC_BIT_GLOBAL_EN];
        default: global_enable <= global_enable;
      endcase
    end
  end

  // event status: a group sees any hardware request; write one to clear,
  // a new event in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_status <= `IPRC_RST_EV;
      event_mask <= `IPRC_RST_EV;
    end else begin
      if (wr_lane0 && wr_hit && wr_idx == `IPRC_IDX_EVST) begin
        event_status <= (event_status & ~w_data_q[1:0]) | {(|hw_set1), (|hw_set0)};
      end else begin
        event_status <= event_status | {(|hw_set1), (|hw_set0)};
      end
      if (wr_lane0 && wr_hit && wr_idx == `IPRC_IDX_EVMASK) begin
        event_mask <= w_data_q[1:0];
      end
    end
  end

  // interrupt line from unmasked events
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(event_status & event_mask);
    end
  end

  // per source priority decode, vector 0-7 first group, 8-15 pin group
  assign pending = {request_group1_pins, request_group0};
  assign enh_all = {enable_high_group1, enable_high_group0};
  assign enl_all = {enable_low_group1, enable_low_group0};

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_src
      // high bit first: 00 off, 01 level 1, 10 level 2, 11 level 3
      assign src_level[gi] = pending[gi] ? {enh_all[gi], enl_all[gi]} : 2'h0;
    end
  endgenerate

  // pick highest level; ties go to the higher vector number, a fixed order
  // that keeps the selection cheap rather than fair
  always_comb begin
    best_level = 2'h0;
    best_vector = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (src_level[i] != 2'h0 && src_level[i] >= best_level) begin
        best_level = src_level[i];
        best_vector = 4'(i);
      end
    end
  end

  // forward to the core only while globally enabled; watchdog never passes here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_irq_valid <= 1'b0;
      core_irq_vector <= 4'h0;
      core_irq_level <= 2'h0;
    end else begin
      core_irq_valid <= global_enable && (best_level != 2'h0);
      core_irq_vector <= best_vector;
      core_irq_level <= global_enable ? best_level : 2'h0; // level shown only while offered
    end
  end

  // read decode
  assign rd_idx = s_axi_araddr[13:2];

  always_comb begin
    rd_hit = (s_axi_araddr[15:14] == 2'h0);
    rd_byte = 8'h00;
    case (rd_idx)
      `IPRC_IDX_REQ0: rd_byte = request_group0;
      `IPRC_IDX_ENH0: rd_byte = enable_high_group0;
      `IPRC_IDX_ENL0: rd_byte = enable_low_group0;
      `IPRC_IDX_REQ1: rd_byte = request_group1_pins;
      `IPRC_IDX_ENH1: rd_byte = enable_high_group1;
      `IPRC_IDX_ENL1: rd_byte = enable_low_group1;
      `IPRC_IDX_CTRL: rd_byte = {7'h00, global_enable};
      `IPRC_IDX_EVST: rd_byte = {6'h00, event_status};
      `IPRC_IDX_EVMASK: rd_byte = {6'h00, event_mask};
      `IPRC_IDX_VEC: rd_byte = {core_irq_valid, core_irq_level, 1'b0, core_irq_vector};
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel: data sampled at the address take, answered next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rstate <= IPRC_RS_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `IPRC_RESP_OKAY;
    end else begin
      case (rstate)
        IPRC_RS_IDLE: begin
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? `IPRC_RESP_OKAY : `IPRC_RESP_SLVERR;
            rstate <= IPRC_RS_DATA;
          end else begin
            s_axi_arready <= 1'b1;
          end
        end
        IPRC_RS_DATA: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rstate <= IPRC_RS_IDLE;
          end
        end
        default: begin
          s_axi_arready <= 1'b0;
          s_axi_rvalid <= 1'b0;
          rstate <= IPRC_RS_IDLE;
        end
      endcase
    end
  end

endmodule // iprc_ctrl

// File: iprc_ctrl_chk.sv
// checker for the request/priority block: bus handshakes and core outputs
// assumes it is bound to iprc_ctrl and sees only that module's ports
`timescale 1ns/1ps
module iprc_ctrl_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic core_irq_valid,
  input wire logic [1:0] core_irq_level
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // answer two edges after both channels are taken, address ready drops meanwhile
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  bvalid_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rvalid_clear_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  // one transfer at a time, so readies stay low while answering
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while answering");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready while answering");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  level_valid_a: assert property (core_irq_valid |-> core_irq_level != 2'h0)
    else $error("valid offered at disabled level");
  level_idle_a: assert property (!core_irq_valid |-> core_irq_level == 2'h0)
    else $error("level shown without request");
endmodule // iprc_ctrl_chk

bind iprc_ctrl iprc_ctrl_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .core_irq_valid,
  .core_irq_level);

// File: iprc_core_model.sv
// model of the core side: latches each vectored request it is offered
// assumes one clock shared with the block; the core never acknowledges
`timescale 1ns/1ps
module iprc_core_model
  import iprc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic core_irq_valid,
  input wire logic [3:0] core_irq_vector,
  input wire iprc_level_t core_irq_level,
  output logic [3:0] taken_vector,
  output iprc_level_t taken_level
);
  // clearing is left to software writes, so only capture here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      taken_vector <= 4'h0;
      taken_level <= 2'h0;
    end else if (core_irq_valid) begin
      taken_vector <= core_irq_vector;
      taken_level <= core_irq_level;
    end
  end
endmodule // iprc_core_model

// File: iprc_ctrl_bench.sv
// self-checking bench for the request/priority block over its register bus
// assumes iprc_core_model and the bound checker are compiled alongside
`timescale 1ns/1ps
`include "iprc_regs.svh"
module iprc_ctrl_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [7:0] r0, r1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic core_irq_valid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, core_irq_level, taken_level, r, c;
  logic [3:0] core_irq_vector, taken_vector;
  int n_errors, n_checks, i;

  iprc_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .timer2_request(r0[7]), .timer1_request(r0[6]), .timer0_request(r0[5]),
    .serial0_rx_request(r0[4]), .serial0_tx_request(r0[3]), .twowire_request(r0[2]),
    .sync_serial_request(r0[1]), .converter_request(r0[0]), .port_pin7_request(r1[7]),
    .port_pin6_request(r1[6]), .port_pin5_request(r1[5]), .port_pin4_request(r1[4]),
    .port_pin3_request(r1[3]), .port_pin2_request(r1[2]), .port_pin1_request(r1[1]),
    .port_pin0_request(r1[0]), .core_irq_valid, .core_irq_vector, .core_irq_level, .irq);
  iprc_core_model u_core (.aclk, .aresetn, .core_irq_valid, .core_irq_vector,
    .core_irq_level, .taken_vector, .taken_level);

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  // write, holding each channel until taken; only the watchdog ends the wait
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= {2'b00, a, 2'b00};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= {2'b00, a, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wc(input logic [11:0] a, input logic [7:0] v);
    wr(a, v);
    chk({30'h0, r}, {30'h0, `IPRC_RESP_OKAY}, "write response");
  endtask

  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    chk(d, {24'h0, e}, "read data");
    chk({30'h0, r}, {30'h0, `IPRC_RESP_OKAY}, "read response");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // watchdog: the tests need a few hundred cycles at most
  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, r0, r1} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`IPRC_IDX_REQ0, 8'h00);
    rc(`IPRC_IDX_ENL0, 8'h00);
    rc(`IPRC_IDX_REQ1, 8'h00);
    wc(`IPRC_IDX_ENL0, 8'ha5);
    rc(`IPRC_IDX_ENL0, 8'ha5);
    $display("test reset and access done");
    // one-cycle pulse per source, globally disabled, so polling must see it
    for (i = 0; i < 8; i++) begin
      @(posedge aclk);
      r0 <= 8'h01 << i;
      r1 <= 8'h80 >> i;
      @(posedge aclk);
      r0 <= 8'h00;
      r1 <= 8'h00;
      rc(`IPRC_IDX_REQ0, 8'h01 << i);
      rc(`IPRC_IDX_REQ1, 8'h80 >> i);
      wc(`IPRC_IDX_REQ0, 8'h00);
      wc(`IPRC_IDX_REQ1, 8'h00);
    end
    $display("test source mapping done");
    // software sets pin 3 in one write, no read-modify-write window
    wc(`IPRC_IDX_CTRL, 8'h01);
    wc(`IPRC_IDX_REQ1, 8'h08);
    for (i = 0; i < 4; i++) begin
      c = i[1:0];
      wc(`IPRC_IDX_ENH1, {4'h0, c[1], 3'h0});
      wc(`IPRC_IDX_ENL1, {4'h0, c[0], 3'h0});
      repeat (3) @(posedge aclk);
      chk({30'h0, core_irq_level}, {30'h0, c}, "level");
      chk({31'h0, core_irq_valid}, {31'h0, |c}, "valid");
      if (c != 2'h0)
        chk({28'h0, core_irq_vector}, 32'h0000000b, "vector");
    end
    // first group converter at low enable bit only
    wc(`IPRC_IDX_REQ1, 8'h00);
    wc(`IPRC_IDX_REQ0, 8'h01);
    repeat (3) @(posedge aclk);
    chk({30'h0, core_irq_level}, 32'h1, "group0 level");
    chk({28'h0, taken_vector}, 32'h0, "core vector");
    chk({30'h0, taken_level}, 32'h1, "core level");
    wc(`IPRC_IDX_CTRL, 8'h00);
    repeat (3) @(posedge aclk);
    chk({31'h0, core_irq_valid}, 32'h0, "disabled valid");
    rc(`IPRC_IDX_REQ0, 8'h01);
    // timer 1 held high across a clearing write: the set must survive it
    @(posedge aclk);
    r0 <= 8'h40;
    wc(`IPRC_IDX_REQ0, 8'h00);
    r0 <= 8'h00;
    rc(`IPRC_IDX_REQ0, 8'h40);
    $display("test priority done");
    // both groups raised events earlier; mask gates the interrupt line
    rc(`IPRC_IDX_EVST, 8'h03);
    chk({31'h0, irq}, 32'h0, "masked irq");
    wc(`IPRC_IDX_EVMASK, 8'h02);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wc(`IPRC_IDX_EVST, 8'h03);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    @(posedge aclk);
    r0 <= 8'h04;
    @(posedge aclk);
    r0 <= 8'h00;
    rc(`IPRC_IDX_EVST, 8'h01);
    chk({31'h0, irq}, 32'h0, "other group masked");
    $display("test interrupt line done");
    // unmapped index answers with an error and no effect
    wr(12'h000, 8'hff);
    chk({30'h0, r}, {30'h0, `IPRC_RESP_SLVERR}, "unmapped write");
    rd(12'h000);
    chk({30'h0, r}, {30'h0, `IPRC_RESP_SLVERR}, "unmapped read");
    $display("test unmapped done");
    summarize();
  end
endmodule // iprc_ctrl_bench
